// ===== rtl/bpss_sequencer.sv
`timescale 1ns/1ps
module bpss_sequencer (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        step_clock,
	input  wire logic        direction_select,
	input  wire logic        step_size_select,
	input  wire logic        idle_coil_impedance_select,
	input  wire logic        bias_open,
	input  wire logic        bias_standby,
	output logic      [3:0]  high_side_switch,
	output logic      [3:0]  low_side_switch,
	output logic             home_phase_flag,
	output logic             home_phase_flag_oe,
	output logic             coil_current_reduced
);
	import bpss_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic [2:0] phase_to_idx(input bpss_phase_t ph);
		logic [2:0] idx;
		idx = 3'h0;
		case (ph)
			BPSS_PH_A: idx = 3'h0;
			BPSS_PH_B: idx = 3'h1;
			BPSS_PH_C: idx = 3'h2;
			BPSS_PH_D: idx = 3'h3;
			BPSS_PH_E: idx = 3'h4;
			BPSS_PH_F: idx = 3'h5;
			BPSS_PH_G: idx = 3'h6;
			BPSS_PH_H: idx = 3'h7;
			default:   idx = 3'h0;
		endcase
		return idx;
	endfunction

	function automatic bpss_phase_t idx_to_phase(input logic [2:0] idx);
		bpss_phase_t ph;
		ph = BPSS_PH_A;
		case (idx)
			3'h0:    ph = BPSS_PH_A;
			3'h1:    ph = BPSS_PH_B;
			3'h2:    ph = BPSS_PH_C;
			3'h3:    ph = BPSS_PH_D;
			3'h4:    ph = BPSS_PH_E;
			3'h5:    ph = BPSS_PH_F;
			3'h6:    ph = BPSS_PH_G;
			3'h7:    ph = BPSS_PH_H;
			default: ph = BPSS_PH_A;
		endcase
		return ph;
	endfunction

	// quadrature pattern, coil a then coil b
	function automatic logic [3:0] phase_coils(input bpss_phase_t ph);
		logic [3:0] c;
		c = {BPSS_COIL_POS, BPSS_COIL_POS};
		case (ph)
			BPSS_PH_A: c = {BPSS_COIL_POS, BPSS_COIL_POS};
			BPSS_PH_B: c = {BPSS_COIL_OFF, BPSS_COIL_POS};
			BPSS_PH_C: c = {BPSS_COIL_NEG, BPSS_COIL_POS};
			BPSS_PH_D: c = {BPSS_COIL_NEG, BPSS_COIL_OFF};
			BPSS_PH_E: c = {BPSS_COIL_NEG, BPSS_COIL_NEG};
			BPSS_PH_F: c = {BPSS_COIL_OFF, BPSS_COIL_NEG};
			BPSS_PH_G: c = {BPSS_COIL_POS, BPSS_COIL_NEG};
			BPSS_PH_H: c = {BPSS_COIL_POS, BPSS_COIL_OFF};
			default:   c = {BPSS_COIL_POS, BPSS_COIL_POS};
		endcase
		return c;
	endfunction

	// switches of one coil as {neg_hs, pos_hs, neg_ls, pos_ls}
	function automatic logic [3:0] coil_switches(input bpss_coil_t c, input logic low_z);
		logic [3:0] s;
		s = 4'h0;
		case (c)
			BPSS_COIL_POS: s = 4'h6;
			BPSS_COIL_NEG: s = 4'h9;
			BPSS_COIL_OFF: s = low_z ? 4'hc : 4'h0;
			default:       s = 4'h0;
		endcase
		return s;
	endfunction

	// next phase index; full steps always land on an even, two-coil index
	function automatic logic [2:0] next_index(
		input logic [2:0] idx,
		input logic       backward,
		input logic       half
	);
		logic [2:0] n;
		n = idx;
		if (half) begin
			n = backward ? idx - 3'h1 : idx + 3'h1;
		end else if (backward) begin
			// from an odd half phase, fall back to the nearest two-coil phase
			n = idx[0] ? idx - 3'h1 : idx - 3'h2;
		end else begin
			n = {idx[2:1] + 2'h1, 1'b0};
		end
		return n;
	endfunction

	// register select, one-hot as {pins, status, ctrl}
	function automatic logic [2:0] reg_select(input logic [11:0] a);
		logic [2:0] sel;
		sel = 3'h0;
		case (a)
			BPSS_CTRL_OFS:   sel = 3'h1;
			BPSS_STATUS_OFS: sel = 3'h2;
			BPSS_PINS_OFS:   sel = 3'h4;
			default:         sel = 3'h0;
		endcase
		return sel;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// apb slave

	logic [1:0]  ctrl;
	logic [1:0]  next_ctrl;
	logic [31:0] next_prdata;
	logic        next_pready;
	logic        next_pslverr;
	logic        sw_step;
	logic        setup;
	logic        access;
	logic [2:0]  reg_sel;
	logic        mapped;
	logic [31:0] ctrl_word;
	logic [31:0] status_word;
	logic [31:0] pins_word;
	bpss_phase_t phase;
	logic        set_active;

	assign setup  = psel & ~penable;
	assign access = psel & penable & pready;
	assign reg_sel = reg_select(paddr);
	assign mapped  = |reg_sel;

	always_comb begin
		ctrl_word = 32'h0;
		ctrl_word[BPSS_CTRL_SET_BIT] = ctrl[BPSS_CTRL_SET_BIT];
		status_word = 32'h0;
		status_word[BPSS_ST_PHASE_LSB +: 3] = phase_to_idx(phase);
		status_word[BPSS_ST_HALF_BIT]       = step_size_select;
		status_word[BPSS_ST_SET_BIT]        = set_active;
		status_word[BPSS_ST_HOME_BIT]       = home_phase_flag_oe;
		status_word[BPSS_ST_STANDBY_BIT]    = coil_current_reduced;
		pins_word = 32'h0;
		pins_word[BPSS_PIN_HS_LSB +: 4] = high_side_switch;
		pins_word[BPSS_PIN_LS_LSB +: 4] = low_side_switch;
	end

	// read data is fetched in the setup cycle, so every access is wait-free
	always_comb begin
		next_prdata  = prdata;
		next_pready  = setup;
		next_pslverr = 1'b0;
		if (setup) begin
			next_pslverr = ~mapped;
			next_prdata  = 32'h0;
			if (!pwrite) begin
				case (reg_sel)
					3'h1:    next_prdata = ctrl_word;
					3'h2:    next_prdata = status_word;
					3'h4:    next_prdata = pins_word;
					default: next_prdata = 32'h0;
				endcase
			end
		end
	end

	// the step bit is a one-cycle strobe and ctrl_word leaves it out, so it always reads back as zero
	always_comb begin
		next_ctrl = ctrl;
		next_ctrl[BPSS_CTRL_STEP_BIT] = 1'b0;
		if (access && pwrite && reg_sel[0]) begin
			next_ctrl[BPSS_CTRL_SET_BIT]  = pwdata[BPSS_CTRL_SET_BIT];
			next_ctrl[BPSS_CTRL_STEP_BIT] = pwdata[BPSS_CTRL_STEP_BIT];
		end
		sw_step = ctrl[BPSS_CTRL_STEP_BIT];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= BPSS_CTRL_RESET[1:0];
		end else begin
			ctrl <= next_ctrl;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			prdata  <= next_prdata;
			pready  <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// step edge detection

	logic        step_clock_prev;
	logic        next_step_clock_prev;
	logic        step_edge;

	// a pin level or the software set bit both act as an open bias input
	assign set_active = bias_open | ctrl[BPSS_CTRL_SET_BIT];

	always_comb begin
		next_step_clock_prev = step_clock;
		// pin taken as synchronous, so one flop is enough for the edge
		step_edge = (step_clock & ~step_clock_prev) | sw_step;
	end

	// idle level of the pin is low, so no false edge follows reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			step_clock_prev <= 1'b0;
		end else begin
			step_clock_prev <= next_step_clock_prev;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// phase sequencer

	logic [2:0]  cur_idx;
	logic [2:0]  step_idx;
	bpss_phase_t next_phase;

	assign cur_idx = phase_to_idx(phase);

	always_comb begin
		step_idx   = next_index(cur_idx, direction_select, step_size_select);
		next_phase = phase;
		if (set_active) begin
			next_phase = BPSS_PH_A;
		end else if (step_edge) begin
			// direction and step size are taken with the step edge
			next_phase = idx_to_phase(step_idx);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase <= BPSS_PH_A;
		end else begin
			phase <= next_phase;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// output decode

	logic [3:0]  coils;
	logic        low_z;
	logic [1:0]  coil_hs [2];
	logic [1:0]  coil_ls [2];
	logic [3:0]  next_hs;
	logic [3:0]  next_ls;

	always_comb begin
		coils = phase_coils(next_phase);
		// impedance select only matters for single-coil phases of half stepping
		low_z = idle_coil_impedance_select & step_size_select;
	end

	// coil a is the upper pair of the pattern and owns outputs 0 and 1
	for (genvar k = 0; k < 2; k++) begin : g_coil
		logic [3:0] sw;
		assign sw         = coil_switches(bpss_coil_t'(coils[3 - 2 * k -: 2]), low_z);
		assign coil_hs[k] = sw[3:2];
		assign coil_ls[k] = sw[1:0];
	end

	always_comb begin
		next_hs = {coil_hs[1], coil_hs[0]};
		next_ls = {coil_ls[1], coil_ls[0]};
		if (set_active) begin
			next_hs = BPSS_SW_OFF;
			next_ls = BPSS_SW_OFF;
		end
	end

	// bias return drives phase A at once since outputs follow next_phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			high_side_switch <= BPSS_SW_OFF;
			low_side_switch  <= BPSS_SW_OFF;
		end else begin
			high_side_switch <= next_hs;
			low_side_switch  <= next_ls;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// home flag and standby level

	logic        next_home_oe;
	logic        next_reduced;

	always_comb begin
		next_home_oe = (next_phase == BPSS_PH_A);
		// standby is only a current level, never a sequencer reset
		next_reduced = bias_standby;
	end

	// open-collector pin: the data stays low and only the enable moves
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			home_phase_flag      <= 1'b0;
			home_phase_flag_oe   <= 1'b1;
			coil_current_reduced <= 1'b0;
		end else begin
			home_phase_flag      <= 1'b0;
			home_phase_flag_oe   <= next_home_oe;
			coil_current_reduced <= next_reduced;
		end
	end

endmodule // bpss_sequencer

// ===== rtl/bpss_pkg.sv
package bpss_pkg;

	// register byte offsets
	localparam logic [11:0] BPSS_CTRL_OFS    = 12'h000;
	localparam logic [11:0] BPSS_STATUS_OFS  = 12'h004;
	localparam logic [11:0] BPSS_PINS_OFS    = 12'h008;

	// control register fields
	localparam int          BPSS_CTRL_SET_BIT  = 0;
	localparam int          BPSS_CTRL_STEP_BIT = 1;
	localparam logic [31:0] BPSS_CTRL_RESET    = 32'h0000_0000;

	// status register fields
	localparam int          BPSS_ST_PHASE_LSB   = 0;
	localparam int          BPSS_ST_HALF_BIT    = 4;
	localparam int          BPSS_ST_SET_BIT     = 5;
	localparam int          BPSS_ST_HOME_BIT    = 6;
	localparam int          BPSS_ST_STANDBY_BIT = 7;

	// pin readback fields
	localparam int          BPSS_PIN_HS_LSB = 0;
	localparam int          BPSS_PIN_LS_LSB = 4;

	// output index order inside the switch vectors
	localparam int          BPSS_A_POS = 0;
	localparam int          BPSS_A_NEG = 1;
	localparam int          BPSS_B_POS = 2;
	localparam int          BPSS_B_NEG = 3;

	localparam logic [3:0]  BPSS_SW_OFF = 4'h0;

	// phase positions, gray coded along the forward path
	typedef enum logic [2:0] {
		BPSS_PH_A = 3'h0,
		BPSS_PH_B = 3'h1,
		BPSS_PH_C = 3'h3,
		BPSS_PH_D = 3'h2,
		BPSS_PH_E = 3'h6,
		BPSS_PH_F = 3'h7,
		BPSS_PH_G = 3'h5,
		BPSS_PH_H = 3'h4
	} bpss_phase_t;

	// drive of one coil
	typedef enum logic [1:0] {
		BPSS_COIL_OFF = 2'h0,
		BPSS_COIL_POS = 2'h1,
		BPSS_COIL_NEG = 2'h2
	} bpss_coil_t;

endpackage

// ===== tb/bpss_checker.sv
`timescale 1ns/1ps
module bpss_checker (
	input wire logic       pclk,
	input wire logic       presetn,
	input wire logic       psel,
	input wire logic       penable,
	input wire logic       pready,
	input wire logic       step_clock,
	input wire logic       step_size_select,
	input wire logic       idle_coil_impedance_select,
	input wire logic       bias_open,
	input wire logic       bias_standby,
	input wire logic [3:0] high_side_switch,
	input wire logic [3:0] low_side_switch,
	input wire logic       home_phase_flag_oe,
	input wire logic       coil_current_reduced
);
	import bpss_pkg::*;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// sw[7:4] high sides, sw[3:0] low sides
	wire logic [7:0] sw = {high_side_switch, low_side_switch};
	////////////////////////////////////////////////////////////////////////////////
	property p_set_off; bias_open |=> sw == 8'h00 && home_phase_flag_oe; endproperty
	a_set_off: assert property (p_set_off) else $error("outputs live under set");
	property p_release; bias_open ##1 !bias_open |=> sw == 8'h5a; endproperty
	a_release: assert property (p_release) else $error("release not in phase a");
	property p_move; !bias_open && step_clock && !$past(step_clock) |=> sw != $past(sw);
	endproperty
	a_move: assert property (p_move) else $error("step edge left outputs unchanged");
	property p_full; !bias_open && step_clock && !$past(step_clock) && !step_size_select
		|=> sw[1:0] != 2'h0 && sw[3:2] != 2'h0; endproperty
	a_full: assert property (p_full) else $error("full step left a coil idle");
	property p_idle_off; !bias_open && step_clock && !$past(step_clock) && step_size_select
		&& !idle_coil_impedance_select
		|=> (sw[1:0] != 2'h0 || sw[5:4] == 2'h0) && (sw[3:2] != 2'h0 || sw[7:6] == 2'h0);
	endproperty
	a_idle_off: assert property (p_idle_off) else $error("idle coil not floating");
	property p_idle_high; !bias_open && step_clock && !$past(step_clock) && step_size_select
		&& idle_coil_impedance_select
		|=> (sw[1:0] != 2'h0 || sw[5:4] == 2'h3) && (sw[3:2] != 2'h0 || sw[7:6] == 2'h3);
	endproperty
	a_idle_high: assert property (p_idle_high) else $error("idle coil high sides off");
	property p_no_short; (sw[7:4] & sw[3:0]) == 4'h0; endproperty
	a_no_short: assert property (p_no_short) else $error("both switches of an output on");
	property p_home; home_phase_flag_oe == (sw == 8'h5a || sw == 8'h00); endproperty
	a_home: assert property (p_home) else $error("home flag disagrees with outputs");
	property p_standby; $rose(bias_standby) && !bias_open && !step_clock
		|=> coil_current_reduced && $stable(sw); endproperty
	a_standby: assert property (p_standby) else $error("standby disturbed sequencer");
	property p_ready; psel && !penable |=> pready; endproperty
	a_ready: assert property (p_ready) else $error("no ready after setup");
endmodule // bpss_checker
bind bpss_sequencer bpss_checker chk_u (.pclk, .presetn, .psel, .penable, .pready,
	.step_clock, .step_size_select, .idle_coil_impedance_select, .bias_open, .bias_standby,
	.high_side_switch, .low_side_switch, .home_phase_flag_oe, .coil_current_reduced);

// ===== tb/bpss_ctrl_model.sv
`timescale 1ns/1ps
module bpss_ctrl_model (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic go,
	input  wire logic set_req,
	output logic      step_clock,
	output logic      bias_open
);
	logic [1:0] pu;
	logic [1:0] next_pu;
	logic       next_step_clock;
	// never two rises without a low cycle between
	always_comb begin
		next_step_clock = go && !step_clock;
		next_pu = (pu == 2'h3) ? pu : pu + 2'h1;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			step_clock <= 1'b0;
			pu <= 2'h0;
		end else begin
			step_clock <= next_step_clock;
			pu <= next_pu;
		end
	end
	// bias held open while supplies settle
	assign bias_open = set_req || pu != 2'h3;
endmodule // bpss_ctrl_model

// ===== tb/bpss_sequencer_tb.sv
`timescale 1ns/1ps
module bpss_sequencer_tb;
	import bpss_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, go, set_req, err;
	logic        direction_select, step_size_select, idle_coil_impedance_select;
	logic        bias_open, bias_standby, step_clock, home_phase_flag, home_phase_flag_oe;
	logic        coil_current_reduced;
	logic [3:0]  high_side_switch, low_side_switch;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	int          n_fail, checks;
	// {dir, half, idle high, home}, high sides, low sides
	logic [11:0] rows [14] = '{12'h448, 12'h469, 12'h6e1, 12'h2a5, 12'h096, 12'h15a, 12'h896,
		12'heb4, 12'h8a5, 12'hc21, 12'he69, 12'he78, 12'hd5a, 12'hed2};
	bpss_sequencer dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .step_clock, .direction_select, .step_size_select,
		.idle_coil_impedance_select, .bias_open, .bias_standby, .high_side_switch,
		.low_side_switch, .home_phase_flag, .home_phase_flag_oe, .coil_current_reduced);
	bpss_ctrl_model ctl_u (.pclk, .presetn, .go, .set_req, .step_clock, .bias_open);
	////////////////////////////////////////////////////////////////////////////////
	task automatic final_report;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic outs(input logic [7:0] s, input logic oe);
		cmp("switches", {24'h0, s}, {24'h0, high_side_switch, low_side_switch});
		cmp("home_oe", {31'h0, oe}, {31'h0, home_phase_flag_oe});
		cmp("home_flag", 32'h0, {31'h0, home_phase_flag});
	endtask
	// the wait is bounded so a silent slave cannot hang the run
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int   i;
		logic ok;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		ok = (pready === 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// one idle edge keeps two requests from writing psel in one time step
		@(posedge pclk);
		if (!ok) begin
			n_fail++;
			final_report();
		end
	endtask
	task automatic step;
		go <= 1'b1;
		@(posedge pclk);
		go <= 1'b0;
		repeat (2) @(posedge pclk);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	initial begin
		n_fail = 0;
		checks = 0;
		{presetn, psel, penable, pwrite, go, set_req, bias_standby} = '0;
		{direction_select, step_size_select, idle_coil_impedance_select} = '0;
		paddr = '0;
		pwdata = '0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		outs(8'h00, 1'b1);
		repeat (4) @(posedge pclk);
		outs(8'h5a, 1'b1);
		foreach (rows[i]) begin
			{direction_select, step_size_select, idle_coil_impedance_select} <= rows[i][11:9];
			step();
			outs(rows[i][7:0], rows[i][8]);
		end
		apb(1'b0, BPSS_STATUS_OFS, 32'h0);
		cmp("status", 32'h17, rd);
		cmp("slverr", 32'h0, {31'h0, err});
		bias_standby <= 1'b1;
		repeat (2) @(posedge pclk);
		cmp("reduced", 32'h1, {31'h0, coil_current_reduced});
		{direction_select, step_size_select, idle_coil_impedance_select} <= 3'h7;
		step();
		outs(8'h96, 1'b0);
		apb(1'b0, BPSS_STATUS_OFS, 32'h0);
		cmp("status", 32'h96, rd);
		bias_standby <= 1'b0;
		set_req <= 1'b1;
		step();
		outs(8'h00, 1'b1);
		set_req <= 1'b0;
		{direction_select, idle_coil_impedance_select} <= 2'h0;
		repeat (2) @(posedge pclk);
		outs(8'h5a, 1'b1);
		step();
		outs(8'h48, 1'b0);
		apb(1'b1, BPSS_CTRL_OFS, 32'h1);
		apb(1'b0, BPSS_STATUS_OFS, 32'h0);
		cmp("status", 32'h70, rd);
		apb(1'b1, BPSS_CTRL_OFS, 32'h0);
		apb(1'b1, BPSS_CTRL_OFS, 32'h2);
		apb(1'b0, BPSS_PINS_OFS, 32'h0);
		cmp("pins", 32'h84, rd);
		apb(1'b0, BPSS_CTRL_OFS, 32'h0);
		cmp("ctrl", 32'h0, rd);
		apb(1'b0, 12'h00c, 32'h0);
		cmp("slverr", 32'h1, {31'h0, err});
		cmp("unmapped", 32'h0, rd);
		final_report();
	end
endmodule // bpss_sequencer_tb
